/* File: verif/amp_timer_model.sv */
/*
  Far-side model: cycle timer strobes and amplifier status feedback.
  Assumes one clock; strobes are one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_timer_model
#(
  parameter int unsigned AXES = 2  // Axes fed back
)
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic [AXES-1:0] amp_inpos,   // Amplifier settled, per axis
  output logic                 op_tick,     // Every second cycle
  output logic                 main_tick,   // Every eighth cycle
  output logic [AXES*16-1:0]   amp_status   // Status words
);
  logic [2:0] cnt;  // Free cycle timer

  // Timer runs from reset release
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;

  assign op_tick   = cnt[0];
  assign main_tick = (cnt == 3'h7);

  // Bits other than 12 toggle so nothing may lean on them
  always_comb
  begin
    amp_status = {AXES{cnt[0] ? 16'hA5A5 : 16'h5A5A}};
    for (int a = 0; a < AXES; a++)
      amp_status[a*16+12] = amp_inpos[a];
  end
endmodule : amp_timer_model
`default_nettype wire

/* File: verif/testbench.sv */
/*
  Self-checking bench for the axis status flag logic with two axes.
  Assumes the timer model supplies the operation and main strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  localparam int unsigned AX = 2;  // Axes under test
  logic clk = 1'b0, arst_n = 1'b0, op_tick, main_tick;
  logic [7:0] cmd_bits = '0, reg_req_valid = '0, reg_req_value = '0, legacy_bits;
  logic [AX-1:0] prog_start = '0, home_start = '0, speed_start = '0, spdpos_start = '0;
  logic [AX-1:0] jog_start = '0, mpg_start = '0, st_start = '0, pos_done = '0, mid_stop = '0;
  logic [AX-1:0] switch_to_pos = '0, speed_mode = '0, st_speed_mode = '0, decel_started = '0;
  logic [AX-1:0] continuous_mode = '0, homing = '0, prox_dog = '0, home_zero_method = '0;
  logic [AX-1:0] cur_change = '0, servo_err = '0, amp_power = '0, zero_seen = '0, amp_inpos = '0;
  logic [AX-1:0] minor_err = '0, major_err = '0, complete_flag_clear_cmd = '0, error_reset_cmd = '0;
  logic [AX*16-1:0] amp_status, err_code = '0, minor_error_code_reg, major_error_code_reg;
  logic [AX*32-1:0] droop = '0, inpos_range = '0, cmd_diff = '0, cmd_inpos_range = '0;
  logic all_axes_servo_on, sequencer_ready;
  logic [2:0] mpg_enable;
  logic [AX*20-1:0] status_map;
  int miscompares = 0, num_checks = 0, cycles = 0;

  initial forever #4 clk = ~clk;

  amp_timer_model #(.AXES(AX)) i_amp_timer_model (.clk, .arst_n, .amp_inpos, .op_tick,
    .main_tick, .amp_status);
  axis_status_flag_logic #(.AXES(AX)) i_axis_status_flag_logic (.clk, .arst_n, .op_tick,
    .main_tick, .cmd_bits, .reg_req_valid, .reg_req_value, .prog_start, .home_start,
    .speed_start, .spdpos_start, .jog_start, .mpg_start, .st_start, .pos_done, .mid_stop,
    .switch_to_pos, .speed_mode, .st_speed_mode, .decel_started, .continuous_mode, .homing,
    .prox_dog, .home_zero_method, .cur_change, .servo_err, .amp_power, .amp_status, .droop,
    .inpos_range, .cmd_diff, .cmd_inpos_range, .zero_seen, .minor_err, .major_err, .err_code,
    .complete_flag_clear_cmd, .error_reset_cmd, .legacy_bits, .all_axes_servo_on,
    .sequencer_ready, .mpg_enable, .status_map, .minor_error_code_reg, .major_error_code_reg);

  // Flag k of axis a in the status map
  function automatic logic flag_at(input int a, input int k);
    return status_map[a*20+k];
  endfunction : flag_at

  // One-cycle pulse of an event input
  task automatic kick(input int k, input int a);
    @(negedge clk);
    case (k)
      0: prog_start[a] = 1'b1;
      1: spdpos_start[a] = 1'b1;
      2: speed_start[a] = 1'b1;
      3: jog_start[a] = 1'b1;
      4: mpg_start[a] = 1'b1;
      5: st_start[a] = 1'b1;
      6: home_start[a] = 1'b1;
      7: pos_done[a] = 1'b1;
      8: switch_to_pos[a] = 1'b1;
      default: zero_seen[a] = 1'b1;
    endcase
    @(negedge clk);
    {prog_start, spdpos_start, speed_start, jog_start, mpg_start, st_start, home_start,
      pos_done, switch_to_pos, zero_seen} = '0;
  endtask : kick

  // Command bits and register requests, reserved bits left low
  task automatic t_cmd;
    @(negedge clk);
    cmd_bits[1:0] = 2'h3;
    reg_req_valid[1:0] = 2'h3;
    @(negedge clk);
    reg_req_valid[1:0] = 2'h0;
    `CHK(legacy_bits[1:0], 2'h3)
    cmd_bits[7:5] = 3'h5;
    cmd_bits[2] = 1'b1;
    repeat (9) @(negedge clk);
    `CHK({sequencer_ready, all_axes_servo_on, mpg_enable}, 5'h1D)
    reg_req_valid[0] = 1'b1;
    cmd_bits[2] = 1'b0;
    @(negedge clk);
    reg_req_valid[0] = 1'b0;
    `CHK(legacy_bits[2:0], 3'h3)
    repeat (3) @(negedge clk);
    `CHK(all_axes_servo_on, 1'b0)
    reg_req_valid[3] = 1'b1;
    reg_req_value[3] = 1'b1;
    @(negedge clk);
    reg_req_valid[3] = 1'b0;
    `CHK(legacy_bits[3:0], 4'hB)
  endtask : t_cmd

  // Start and positioning complete flags
  task automatic t_start;
    kick(3, 0);
    kick(0, 1);
    `CHK({flag_at(1, 0), flag_at(0, 0)}, 2'h2)
    @(negedge clk) complete_flag_clear_cmd[1] = 1'b1;
    @(negedge clk) `CHK(flag_at(1, 0), 1'b0)
    complete_flag_clear_cmd[1] = 1'b0;
    kick(0, 1);
    kick(7, 1);
    `CHK({flag_at(1, 1), flag_at(1, 0)}, 2'h2)
    mid_stop[0] = 1'b1;
    kick(7, 0);
    mid_stop[0] = 1'b0;
    `CHK(flag_at(0, 1), 1'b0)
    kick(0, 1);
    `CHK(flag_at(1, 1), 1'b0)
    kick(7, 1);
    @(negedge clk) complete_flag_clear_cmd[1] = 1'b1;
    @(negedge clk) `CHK(flag_at(1, 1), 1'b0)
  endtask : t_start

  // In-position on axis 0 under one set of conditions
  task automatic inpos_case(input logic [5:0] v, input logic exp);
    {servo_err[0], cur_change[0], homing[0], prox_dog[0], decel_started[0],
      continuous_mode[0]} = v;
    repeat (3) @(negedge clk);
    `CHK(flag_at(0, 2), exp)
  endtask : inpos_case

  task automatic t_inpos;
    droop[31:0] = 32'h4;
    inpos_range[31:0] = 32'h10;
    inpos_case(6'h02, 1'b1);
    @(negedge clk iff op_tick);
    kick(0, 0);
    `CHK(flag_at(0, 2), 1'b0)
    amp_power[0] = 1'b1;
    inpos_case(6'h02, 1'b0);
    amp_inpos[0] = 1'b1;
    inpos_case(6'h02, 1'b1);
    inpos_case(6'h22, 1'b0);
    inpos_case(6'h12, 1'b0);
    inpos_case(6'h0A, 1'b0);
    inpos_case(6'h0E, 1'b1);
    inpos_case(6'h00, 1'b0);
    inpos_case(6'h01, 1'b1);
  endtask : t_inpos

  // Command in-position, speed flag and switching latch on axis 1
  task automatic t_speed;
    cmd_diff[63:32] = 32'h3;
    cmd_inpos_range[63:32] = 32'h8;
    repeat (3) @(negedge clk);
    `CHK(flag_at(1, 3), 1'b1)
    speed_mode[1] = 1'b1;
    kick(2, 1);
    repeat (3) @(negedge clk);
    `CHK({flag_at(1, 4), flag_at(1, 3)}, 2'h2)
    st_speed_mode[1] = 1'b1;
    @(negedge clk) `CHK(flag_at(1, 4), 1'b0)
    {st_speed_mode[1], speed_mode[1]} = 2'h0;
    kick(8, 1);
    repeat (3) @(negedge clk);
    `CHK({flag_at(1, 5), flag_at(1, 3)}, 2'h3)
    for (int k = 0; k < 6; k++)
    begin
      kick(8, 1);
      kick(k, 1);
      `CHK(flag_at(1, 5), 1'b0)
    end
  endtask : t_speed

  // Zero pass, errors, then a second reset
  task automatic t_zero_err;
    kick(9, 0);
    kick(6, 0);
    `CHK(flag_at(0, 6), 1'b1)
    home_zero_method[0] = 1'b1;
    kick(6, 0);
    `CHK(flag_at(0, 6), 1'b0)
    kick(9, 0);
    `CHK(flag_at(0, 6), 1'b1)
    {minor_err[0], major_err[1], err_code} = {2'h3, 16'h0BEE, 16'h0123};
    @(negedge clk) {minor_err, major_err} = '0;
    `CHK({flag_at(1, 7), flag_at(0, 7)}, 2'h3)
    `CHK({major_error_code_reg[31:16], minor_error_code_reg[15:0]}, 32'h0BEE0123)
    error_reset_cmd = 2'h3;
    @(negedge clk) `CHK({flag_at(1, 7), flag_at(0, 7)}, 2'h0)
    arst_n = 1'b0;
    @(negedge clk) `CHK({status_map, minor_error_code_reg, legacy_bits}, '0)
    arst_n = 1'b1;
  endtask : t_zero_err

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk) `CHK({status_map, major_error_code_reg, legacy_bits}, '0)
    t_cmd();
    t_start();
    t_inpos();
    t_speed();
    t_zero_err();
    summarize();
  end
endmodule : testbench
`default_nettype wire

/* File: verilog/axis_flag_cell.sv */
/*
  One axis worth of status flags and stored error codes.
  Assumes event inputs are single-cycle pulses on the operation cycle and
  levels are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module axis_flag_cell
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        op_tick,            // Operation cycle strobe
  input  wire logic        prog_start,         // Program positioning start done
  input  wire logic        home_start,         // Home return start
  input  wire logic        speed_start,        // Speed control start
  input  wire logic        spdpos_start,       // Speed-position switching start
  input  wire logic        jog_start,          // Jog start
  input  wire logic        mpg_start,          // Pulse generator start
  input  wire logic        st_start,           // Speed-torque start
  input  wire logic        pos_done,           // Command output reached target
  input  wire logic        mid_stop,           // Stop on the way
  input  wire logic        switch_to_pos,      // Speed to position transfer
  input  wire logic        speed_mode,         // Axis in speed control
  input  wire logic        st_speed_mode,      // Speed-torque speed mode
  input  wire logic        decel_started,      // Deceleration has begun
  input  wire logic        continuous_mode,    // Follow-up/oscill./mpg/sync
  input  wire logic        homing,             // Home return in progress
  input  wire logic        prox_dog,           // Proximity dog on
  input  wire logic        home_zero_method,   // Home method clears zero pass
  input  wire logic        cur_change,         // Current value change
  input  wire logic        servo_err,          // Servo error present
  input  wire logic        amp_power,          // Amplifier control power on
  input  wire logic [15:0] amp_status,         // Amplifier status word
  input  wire logic [31:0] droop,              // Following error magnitude
  input  wire logic [31:0] inpos_range,        // In-position range
  input  wire logic [31:0] cmd_diff,           // |command - fed| position
  input  wire logic [31:0] cmd_inpos_range,    // Command in-position range
  input  wire logic        zero_seen,          // Encoder zero passage pulse
  input  wire logic        minor_err,          // Minor error pulse
  input  wire logic        major_err,          // Major error pulse
  input  wire logic [15:0] err_code,           // Code accompanying the error
  input  wire logic        complete_flag_clear_cmd,
  input  wire logic        error_reset_cmd,
  output logic [7:0]       flags,              // Flags in package order
  output logic [15:0]      minor_error_code_reg,
  output logic [15:0]      major_error_code_reg
);
  logic clr_prev;  // Previous clear command for edge detect
  logic any_start; // Any motion start
  logic clr_rise;  // Leading edge of the clear command
  logic inpos_hold; // Suppression of in-position

  assign clr_rise  = complete_flag_clear_cmd & ~clr_prev;
  assign any_start = prog_start | home_start | speed_start | spdpos_start
                   | jog_start | mpg_start | st_start;
  // Forced-off conditions for in-position
  assign inpos_hold = servo_err | cur_change | (homing & ~prox_dog)
                    | (~decel_started & ~continuous_mode & ~homing);

  // Edge memory for the clear command
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      clr_prev <= 1'b0;
    else
      clr_prev <= complete_flag_clear_cmd;

  // Start complete: set wins over clear
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::START_CPL_BIT] <= axis_flag_pkg::FLAG_RESET;
    else if (prog_start)
      flags[axis_flag_pkg::START_CPL_BIT] <= 1'b1;
    else if (clr_rise || pos_done)
      flags[axis_flag_pkg::START_CPL_BIT] <= 1'b0;

  // Positioning complete, also for zero travel
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::POS_CPL_BIT] <= axis_flag_pkg::FLAG_RESET;
    else if (pos_done && !mid_stop && !homing && !speed_mode)
      flags[axis_flag_pkg::POS_CPL_BIT] <= 1'b1;
    else if (clr_rise || prog_start)
      flags[axis_flag_pkg::POS_CPL_BIT] <= 1'b0;

  // In position, refreshed each operation cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::IN_POS_BIT] <= 1'b0;
    else if (prog_start || inpos_hold)
      flags[axis_flag_pkg::IN_POS_BIT] <= 1'b0;
    else if (op_tick)
    begin
      if (amp_power)
        flags[axis_flag_pkg::IN_POS_BIT] <= amp_status[axis_flag_pkg::AMP_INPOS_BIT];
      else
        flags[axis_flag_pkg::IN_POS_BIT] <= droop < inpos_range;
    end

  // Command in position, compared only in position control
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::CMD_IN_POS_BIT] <= 1'b0;
    else if (prog_start || home_start || homing || speed_start || jog_start
             || mpg_start || st_start || speed_mode)
      flags[axis_flag_pkg::CMD_IN_POS_BIT] <= 1'b0;
    else if (op_tick)
      flags[axis_flag_pkg::CMD_IN_POS_BIT] <= cmd_diff < cmd_inpos_range;

  // Speed controlling follows the mode
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::SPEED_CTL_BIT] <= 1'b0;
    else
      flags[axis_flag_pkg::SPEED_CTL_BIT] <= speed_mode & ~st_speed_mode;

  // Switching latch
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::SW_LATCH_BIT] <= 1'b0;
    else if (switch_to_pos)
      flags[axis_flag_pkg::SW_LATCH_BIT] <= 1'b1;
    else if (prog_start || spdpos_start || speed_start || jog_start
             || mpg_start || st_start)
      flags[axis_flag_pkg::SW_LATCH_BIT] <= 1'b0;

  // Zero pass, sticky until system reset or a home start with home_zero_method
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::ZERO_PASS_BIT] <= 1'b0;
    else if (zero_seen && amp_power)
      flags[axis_flag_pkg::ZERO_PASS_BIT] <= 1'b1;
    else if (home_start && home_zero_method)
      flags[axis_flag_pkg::ZERO_PASS_BIT] <= 1'b0;

  // Error flag and code storage
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      flags[axis_flag_pkg::ERR_DET_BIT] <= 1'b0;
    else if (minor_err || major_err)
      flags[axis_flag_pkg::ERR_DET_BIT] <= 1'b1;
    else if (error_reset_cmd)
      flags[axis_flag_pkg::ERR_DET_BIT] <= 1'b0;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      minor_error_code_reg <= axis_flag_pkg::CODE_RESET;
      major_error_code_reg <= axis_flag_pkg::CODE_RESET;
    end
    else
    begin
      if (minor_err)
        minor_error_code_reg <= err_code;
      if (major_err)
        major_error_code_reg <= err_code;
    end

  // Checks
  start_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    prog_start |=> flags[axis_flag_pkg::START_CPL_BIT]) else $error("start flag");
  start_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clr_rise && !prog_start) |=> !flags[axis_flag_pkg::START_CPL_BIT])
    else $error("start clear");
  pos_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    (prog_start && !pos_done) |=> !flags[axis_flag_pkg::POS_CPL_BIT])
    else $error("pos clear");
  pos_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pos_done && !mid_stop && !homing && !speed_mode)
    |=> flags[axis_flag_pkg::POS_CPL_BIT]) else $error("pos set");
  inpos_err_a: assert property (@(posedge clk) disable iff (!arst_n)
    servo_err |=> !flags[axis_flag_pkg::IN_POS_BIT]) else $error("inpos err");
  cmd_speed_a: assert property (@(posedge clk) disable iff (!arst_n)
    speed_mode |=> !flags[axis_flag_pkg::CMD_IN_POS_BIT]) else $error("cmd inpos");
  speed_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_speed_mode |=> !flags[axis_flag_pkg::SPEED_CTL_BIT]) else $error("speed flag");
  latch_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    switch_to_pos |=> flags[axis_flag_pkg::SW_LATCH_BIT]) else $error("latch");
  zero_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (flags[axis_flag_pkg::ZERO_PASS_BIT] && !home_start)
    |=> flags[axis_flag_pkg::ZERO_PASS_BIT]) else $error("zero pass");
  err_code_a: assert property (@(posedge clk) disable iff (!arst_n)
    major_err |=> (flags[axis_flag_pkg::ERR_DET_BIT]
    && major_error_code_reg == $past(err_code))) else $error("err code");
  err_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    (error_reset_cmd && !minor_err && !major_err)
    |=> !flags[axis_flag_pkg::ERR_DET_BIT]) else $error("err reset");
  start_cov_c: cover property (@(posedge clk) prog_start ##[1:50] pos_done);
  switch_cov_c: cover property (@(posedge clk) spdpos_start ##[1:50] switch_to_pos);
  err_cov_c: cover property (@(posedge clk) minor_err ##[1:20] error_reset_cmd);
endmodule : axis_flag_cell
`default_nettype wire

/* File: verilog/axis_flag_pkg.sv */
/*
  Constants shared by the axis status flag logic: flag positions in the
  per-axis status word, the axis stride, command-bit map and reset values.
  Assumes a single clock domain and no bus; all control arrives as ports.
*/
`default_nettype none
package axis_flag_pkg;
  localparam int unsigned AXIS_STRIDE      = 20;   // Bit positions per axis
  localparam int unsigned FLAG_COUNT       = 8;    // Flags kept by this block
  localparam int unsigned START_CPL_BIT    = 0;    // Start complete
  localparam int unsigned POS_CPL_BIT      = 1;    // Positioning complete
  localparam int unsigned IN_POS_BIT       = 2;    // In position
  localparam int unsigned CMD_IN_POS_BIT   = 3;    // Command in position
  localparam int unsigned SPEED_CTL_BIT    = 4;    // Speed controlling
  localparam int unsigned SW_LATCH_BIT     = 5;    // Speed/position latch
  localparam int unsigned ZERO_PASS_BIT    = 6;    // Zero pass
  localparam int unsigned ERR_DET_BIT      = 7;    // Error detected
  localparam int unsigned CMD_BITS         = 8;    // Shared command bits
  localparam int unsigned RESERVED_POINTS  = 55;   // Reserved command area size
  localparam int unsigned AMP_INPOS_BIT    = 12;   // In-position bit of amp status
  localparam int unsigned CODE_W           = 16;   // Error code width
  localparam logic [15:0] CODE_RESET       = 16'h0000;
  localparam logic        FLAG_RESET       = 1'b0;
endpackage : axis_flag_pkg
`default_nettype wire

/* File: verilog/axis_status_flag_logic.sv */
/*
  Per-axis status flags for a multi-axis positioning controller, plus the
  shared command bits that mirror onto legacy bits.
  Assumes the outside processor drives command bits synchronous to clk and
  that op_tick and main_tick are single-cycle strobes from a cycle timer.
*/
// Operation
// - Command bit edges set or clear legacy bit
// - Command bit beats register request same cycle
// - Servo-on per operation cycle; ready/enables main
// - Axis flags at base plus twenty times axis
// - Start complete on program start only
// - Start complete clears on clear edge/completion
// - Positioning complete at command output end
// - Positioning complete clears on clear edge/start
// - Positioning complete sets even for zero travel
// - In-position from droop below range; start clears
// - In-position mirrors amp b12, forced off cases
// - No start suppression in continuous modes, dog
// - Command in-position on small difference, clears
// - Command in-position skipped during speed control
// - Speed-controlling flag tracks speed control mode
// - Switching latch sets on transfer, clears start
// - Zero pass sticky until system reset or zero-clearing home start
// - Some home methods clear zero pass
// - Error flag sets, codes stored per class
// - Error flag clears on error reset
`timescale 1ns/1ps
`default_nettype none
module axis_status_flag_logic
#(
  parameter int unsigned AXES = 8  // Number of axes
)
(
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          op_tick,        // Operation cycle
  input  wire logic                          main_tick,      // Main cycle
  input  wire logic [7:0]                    cmd_bits,       // Shared command bits
  input  wire logic [7:0]                    reg_req_valid,  // Register request strobes
  input  wire logic [7:0]                    reg_req_value,  // Register request levels
  input  wire logic [AXES-1:0]               prog_start,
  input  wire logic [AXES-1:0]               home_start,
  input  wire logic [AXES-1:0]               speed_start,
  input  wire logic [AXES-1:0]               spdpos_start,
  input  wire logic [AXES-1:0]               jog_start,
  input  wire logic [AXES-1:0]               mpg_start,
  input  wire logic [AXES-1:0]               st_start,
  input  wire logic [AXES-1:0]               pos_done,
  input  wire logic [AXES-1:0]               mid_stop,
  input  wire logic [AXES-1:0]               switch_to_pos,
  input  wire logic [AXES-1:0]               speed_mode,
  input  wire logic [AXES-1:0]               st_speed_mode,
  input  wire logic [AXES-1:0]               decel_started,
  input  wire logic [AXES-1:0]               continuous_mode,
  input  wire logic [AXES-1:0]               homing,
  input  wire logic [AXES-1:0]               prox_dog,
  input  wire logic [AXES-1:0]               home_zero_method,
  input  wire logic [AXES-1:0]               cur_change,
  input  wire logic [AXES-1:0]               servo_err,
  input  wire logic [AXES-1:0]               amp_power,
  input  wire logic [AXES*16-1:0]            amp_status,
  input  wire logic [AXES*32-1:0]            droop,
  input  wire logic [AXES*32-1:0]            inpos_range,
  input  wire logic [AXES*32-1:0]            cmd_diff,
  input  wire logic [AXES*32-1:0]            cmd_inpos_range,
  input  wire logic [AXES-1:0]               zero_seen,
  input  wire logic [AXES-1:0]               minor_err,
  input  wire logic [AXES-1:0]               major_err,
  input  wire logic [AXES*16-1:0]            err_code,
  input  wire logic [AXES-1:0]               complete_flag_clear_cmd,
  input  wire logic [AXES-1:0]               error_reset_cmd,
  output logic [7:0]                         legacy_bits,    // Mirrored legacy bits
  output logic                               all_axes_servo_on,   // Sampled per op cycle
  output logic                               sequencer_ready,     // Sampled per main cycle
  output logic [2:0]                         mpg_enable,          // Sampled per main cycle
  output logic [AXES*20-1:0]                 status_map,          // Flags, stride 20
  output logic [AXES*16-1:0]                 minor_error_code_reg,
  output logic [AXES*16-1:0]                 major_error_code_reg
);
  logic [7:0] cmd_prev;   // Command bits one cycle ago
  logic [7:0] cmd_rise;   // Off-to-on edges
  logic [7:0] cmd_fall;   // On-to-off edges
  logic [7:0] next_legacy; // Next legacy bit values

  assign cmd_rise = cmd_bits & ~cmd_prev;
  assign cmd_fall = ~cmd_bits & cmd_prev;

  // Command edge memory
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      cmd_prev <= 8'h00;
    else
      cmd_prev <= cmd_bits;

  // Edges drive legacy bits; register request only when no edge that cycle
  always_comb
  begin
    next_legacy = legacy_bits;
    for (int i = 0; i < 8; i++)
    begin
      if (cmd_rise[i])
        next_legacy[i] = 1'b1;
      else if (cmd_fall[i])
        next_legacy[i] = 1'b0;
      else if (reg_req_valid[i] && !(|(cmd_rise | cmd_fall)))
        next_legacy[i] = reg_req_value[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      legacy_bits <= 8'h00;
    else
      legacy_bits <= next_legacy;

  // Servo-on sampled each operation cycle (bit 2)
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      all_axes_servo_on <= 1'b0;
    else if (op_tick)
      all_axes_servo_on <= legacy_bits[2];

  // Ready (bit 0) and pulse generator enables (bits 5..7) on main cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      sequencer_ready <= 1'b0;
      mpg_enable      <= 3'h0;
    end
    else if (main_tick)
    begin
      sequencer_ready <= legacy_bits[0];
      mpg_enable      <= legacy_bits[7:5];
    end

  // One flag cell per axis, placed with a stride of twenty
  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    logic [7:0] cell_flags; // Eight flags of this axis
    axis_flag_cell u_cell (
      .clk                     (clk),
      .arst_n                  (arst_n),
      .op_tick                 (op_tick),
      .prog_start              (prog_start[a]),
      .home_start              (home_start[a]),
      .speed_start             (speed_start[a]),
      .spdpos_start            (spdpos_start[a]),
      .jog_start               (jog_start[a]),
      .mpg_start               (mpg_start[a]),
      .st_start                (st_start[a]),
      .pos_done                (pos_done[a]),
      .mid_stop                (mid_stop[a]),
      .switch_to_pos           (switch_to_pos[a]),
      .speed_mode              (speed_mode[a]),
      .st_speed_mode           (st_speed_mode[a]),
      .decel_started           (decel_started[a]),
      .continuous_mode         (continuous_mode[a]),
      .homing                  (homing[a]),
      .prox_dog                (prox_dog[a]),
      .home_zero_method        (home_zero_method[a]),
      .cur_change              (cur_change[a]),
      .servo_err               (servo_err[a]),
      .amp_power               (amp_power[a]),
      .amp_status              (amp_status[a*16 +: 16]),
      .droop                   (droop[a*32 +: 32]),
      .inpos_range             (inpos_range[a*32 +: 32]),
      .cmd_diff                (cmd_diff[a*32 +: 32]),
      .cmd_inpos_range         (cmd_inpos_range[a*32 +: 32]),
      .zero_seen               (zero_seen[a]),
      .minor_err               (minor_err[a]),
      .major_err               (major_err[a]),
      .err_code                (err_code[a*16 +: 16]),
      .complete_flag_clear_cmd (complete_flag_clear_cmd[a]),
      .error_reset_cmd         (error_reset_cmd[a]),
      .flags                   (cell_flags),
      .minor_error_code_reg    (minor_error_code_reg[a*16 +: 16]),
      .major_error_code_reg    (major_error_code_reg[a*16 +: 16])
    );
    // Upper twelve positions belong to flags kept elsewhere
    assign status_map[a*axis_flag_pkg::AXIS_STRIDE +: axis_flag_pkg::AXIS_STRIDE] =
      {12'h000, cell_flags};
  end

  legacy_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_rise[0] |=> legacy_bits[0]) else $error("legacy set");
  legacy_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fall[2] |=> !legacy_bits[2]) else $error("legacy clear");
  cmd_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_rise[1] && reg_req_valid[1] && !reg_req_value[1]) |=> legacy_bits[1])
    else $error("cmd priority");
  servo_samp_a: assert property (@(posedge clk) disable iff (!arst_n)
    !op_tick |=> $stable(all_axes_servo_on)) else $error("servo sample");
  ready_samp_a: assert property (@(posedge clk) disable iff (!arst_n)
    main_tick |=> sequencer_ready == $past(legacy_bits[0])) else $error("ready");
  legacy_cov_c: cover property (@(posedge clk) cmd_rise[2] ##[1:20] cmd_fall[2]);
endmodule : axis_status_flag_logic
`default_nettype wire
